// [shared/output_function_map.svh]
// Register offsets, selector codes and reset values for the output mapper
`ifndef OUTPUT_FUNCTION_MAP_SVH
`define OUTPUT_FUNCTION_MAP_SVH

`define SEL_W              16
`define ADDR_W             16
`define OFS_SEL0           16'h0712
`define OFS_SEL1           16'h0714
`define FN_FREE            16'h0001
`define FN_NO_FAULT        16'h0002
`define FN_ACTIVE          16'h0003
`define FN_REL_MOVE        16'h0004
`define FN_POS_WIN         16'h0005
`define FN_VEL_WIN         16'h0006
`define FN_VEL_LOW         16'h0007
`define FN_CUR_LOW         16'h0008
`define FN_HALT_ACK        16'h0009
`define FN_SEQ_START_ACK   16'h000b
`define FN_STANDSTILL      16'h000d
`define FN_SEL_ERROR       16'h000e
`define FN_REF_OK          16'h000f
`define FN_SEL_WARNING     16'h0010
`define FN_SEQ_DONE        16'h0011
`define FN_PREG_1          16'h0012
`define FN_PREG_2          16'h0013
`define FN_PREG_3          16'h0014
`define FN_PREG_4          16'h0015
`define FN_MOVE_POS        16'h0016
`define FN_MOVE_NEG        16'h0017
`define SEL0_DEFAULT       16'h0002
`define SEL1_DEFAULT       16'h0003
`define ST_READY_TO_SWITCH 3'h1
`define ST_SWITCHED_ON     3'h2
`define ST_OP_ENABLED      3'h3

`endif

// [shared/output_function_pkg.sv]
// Types shared by the output function mapper
package output_function_pkg;

    // Drive status conditions feeding the output mapper
    typedef struct packed {
        logic [2:0] op_state;
        logic       rel_move_capture;
        logic       pos_in_window;
        logic       vel_in_window;
        logic       vel_below_thr;
        logic       cur_below_thr;
        logic       halt_ack;
        logic       seq_start_ack;
        logic       standstill;
        logic [3:0] err_class_1_4;
        logic       ref_valid;
        logic       err_class_0;
        logic       seq_done;
        logic [3:0] preg_channel;
        logic       move_pos;
        logic       move_neg;
    } drive_status_t;

    // Register write/read port
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Write outcome of the register store
    typedef enum logic [1:0] {
        WR_IDLE     = 2'b00,
        WR_ACCEPTED = 2'b01,
        WR_REJECTED = 2'b10
    } wr_result_t;

endpackage

// [hdl/selector_store.sv]
// Persistent selector store with power-on snapshot of the active mapping
`timescale 1ns/1ps
`include "output_function_map.svh"

module selector_store
    import output_function_pkg::*;
#(
    parameter logic [15:0] DEFAULT_VAL = `SEL0_DEFAULT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Power-on load strobe
    input  wire logic        power_on_load,
    // Write side
    input  wire logic        wr_ok,
    input  wire logic [15:0] wdata,
    // Stored and active selector
    output logic [15:0]      stored_ff,
    output logic [15:0]      active_ff
);

    // Persistent copy, updated by accepted writes
    always_ff @(posedge clk) begin
        if (rst) begin
            stored_ff <= DEFAULT_VAL;
        end else if (wr_ok) begin
            stored_ff <= wdata;
        end
    end

    // Active copy only reloads at power-on
    always_ff @(posedge clk) begin
        if (rst) begin
            active_ff <= DEFAULT_VAL;
        end else if (power_on_load) begin
            active_ff <= stored_ff;
        end
    end

endmodule

// [hdl/signal_output_function_select.sv]
// Maps drive status conditions onto the two digital signal outputs
`timescale 1ns/1ps
`include "output_function_map.svh"

// Functional notes
// - Code 1 drives the output from a software level.
// - Code 2: ready to switch on, switched on or operation enabled.
// - Code 3: only while operation enabled.
// - Code 4: relative move after capture active or finished.
// - Codes 5 and 6: position or velocity deviation in window.
// - Codes 7 and 8: velocity or current below threshold.
// - Code 9: halt acknowledge.
// - Code 11: motion sequence start acknowledge.
// - Code 13: motor at standstill.
// - Code 14: any selected error of class one to four.
// - Code 15: reference valid.
// - Code 16: any selected class zero warning.
// - Code 17: motion sequence done.
// - Codes 18 to 21: position register channels one to four.
// - Codes 22 and 23: moving positive or negative.
// - Selector writes accepted only with power stage disabled.
// - New selector stored but used only after next power-on.
// - Each output has its own independent selector.
// - Defaults: output zero no-fault, output one active.
// - Outputs keep following their function during errors.
module signal_output_function_select
    import output_function_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Power-on strobe and power stage state
    input  wire logic          power_on_load,
    input  wire logic          power_stage_enabled,
    // Parameter access
    input  wire reg_req_t      req,
    output logic [15:0]        rdata_ff,
    output wr_result_t         wr_result_ff,
    // Software levels for code 1
    input  wire logic [1:0]    sw_level,
    // Drive status conditions
    input  wire drive_status_t status,
    // Digital outputs
    output logic               digital_output_zero,
    output logic               digital_output_one
);

    logic [15:0] stored_sel [2];
    logic [15:0] active_sel [2];
    logic [1:0]  out_ff;
    logic [1:0]  hit;
    logic [1:0]  wr_ok;
    logic [1:0]  nxt_out;

    // Listed function codes only
    function automatic logic code_valid(input logic [15:0] c);
        logic ok;
        ok = 1'b0;
        unique case (c)
            `FN_FREE, `FN_NO_FAULT, `FN_ACTIVE, `FN_REL_MOVE, `FN_POS_WIN,
            `FN_VEL_WIN, `FN_VEL_LOW, `FN_CUR_LOW, `FN_HALT_ACK,
            `FN_SEQ_START_ACK, `FN_STANDSTILL, `FN_SEL_ERROR,
            `FN_REF_OK, `FN_SEL_WARNING, `FN_SEQ_DONE, `FN_PREG_1,
            `FN_PREG_2, `FN_PREG_3, `FN_PREG_4, `FN_MOVE_POS,
            `FN_MOVE_NEG: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Function decode for one output
    function automatic logic map_fn(input logic [15:0] c,
                                    input logic sw,
                                    input drive_status_t s);
        logic v;
        v = 1'b0;
        unique case (c)
            `FN_FREE:          v = sw;
            `FN_NO_FAULT:      v = (s.op_state == `ST_READY_TO_SWITCH) ||
                                   (s.op_state == `ST_SWITCHED_ON) ||
                                   (s.op_state == `ST_OP_ENABLED);
            `FN_ACTIVE:        v = (s.op_state == `ST_OP_ENABLED);
            `FN_REL_MOVE:      v = s.rel_move_capture;
            `FN_POS_WIN:       v = s.pos_in_window;
            `FN_VEL_WIN:       v = s.vel_in_window;
            `FN_VEL_LOW:       v = s.vel_below_thr;
            `FN_CUR_LOW:       v = s.cur_below_thr;
            `FN_HALT_ACK:      v = s.halt_ack;
            `FN_SEQ_START_ACK: v = s.seq_start_ack;
            `FN_STANDSTILL:    v = s.standstill;
            `FN_SEL_ERROR:     v = |s.err_class_1_4;
            `FN_REF_OK:        v = s.ref_valid;
            `FN_SEL_WARNING:   v = s.err_class_0;
            `FN_SEQ_DONE:      v = s.seq_done;
            `FN_PREG_1:        v = s.preg_channel[0];
            `FN_PREG_2:        v = s.preg_channel[1];
            `FN_PREG_3:        v = s.preg_channel[2];
            `FN_PREG_4:        v = s.preg_channel[3];
            `FN_MOVE_POS:      v = s.move_pos;
            `FN_MOVE_NEG:      v = s.move_neg;
            default:           v = 1'b0;
        endcase
        return v;
    endfunction

    // Address hits for the two selectors
    assign hit[0] = (req.addr == `OFS_SEL0);
    assign hit[1] = (req.addr == `OFS_SEL1);

    // One store and one decoder per output
    for (genvar i = 0; i < 2; i++) begin : g_out
        // Write gated by power stage and code check
        assign wr_ok[i] = req.wr_en && hit[i] && !power_stage_enabled &&
                          code_valid(req.wdata);

        // Separate selector per output, defaults differ
        selector_store #(
            .DEFAULT_VAL (i == 0 ? `SEL0_DEFAULT : `SEL1_DEFAULT)
        ) u_store (
            .clk           (clk),
            .rst           (rst),
            .power_on_load (power_on_load),
            .wr_ok         (wr_ok[i]),
            .wdata         (req.wdata),
            .stored_ff     (stored_sel[i]),
            .active_ff     (active_sel[i])
        );

        // Output follows function, no error override
        assign nxt_out[i] = map_fn(active_sel[i], sw_level[i],
                                   status);
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            out_ff <= 2'h0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign digital_output_zero = out_ff[0];
    assign digital_output_one  = out_ff[1];

    // Read data shows the stored selector
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (req.rd_en) begin
            rdata_ff <= hit[0] ? stored_sel[0] :
                        hit[1] ? stored_sel[1] : 16'h0000;
        end
    end

    // Write outcome per request
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_result_ff <= WR_IDLE;
        end else if (req.wr_en && (hit[0] || hit[1])) begin
            wr_result_ff <= (|wr_ok) ? WR_ACCEPTED : WR_REJECTED;
        end else begin
            wr_result_ff <= WR_IDLE;
        end
    end

    // Accepted write lands in stored copy next cycle
    property p_write_stores;
        @(posedge clk) disable iff (rst)
        wr_ok[0] |=> (stored_sel[0] == $past(req.wdata));
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("accepted write not stored");

    // Write with power stage on leaves selector alone
    property p_power_block;
        @(posedge clk) disable iff (rst)
        (req.wr_en && hit[1] && power_stage_enabled) |=>
            $stable(stored_sel[1]);
    endproperty
    a_power_block: assert property (p_power_block)
        else $error("write accepted with power stage enabled");

    // Invalid codes leave selector alone
    property p_reject_code;
        @(posedge clk) disable iff (rst)
        (req.wr_en && hit[0] && !code_valid(req.wdata)) |=>
            $stable(stored_sel[0]);
    endproperty
    a_reject_code: assert property (p_reject_code)
        else $error("unlisted code stored");

    // Active mapping unchanged without power-on
    property p_active_hold;
        @(posedge clk) disable iff (rst)
        !power_on_load |=> $stable(active_sel[0]) && $stable(active_sel[1]);
    endproperty
    a_active_hold: assert property (p_active_hold)
        else $error("active selector changed without power-on");

    // Active code 3 tracks operation enabled state
    property p_active_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[1] == `FN_ACTIVE && !power_on_load) |=>
            (digital_output_one == ($past(status.op_state) == `ST_OP_ENABLED));
    endproperty
    a_active_fn: assert property (p_active_fn)
        else $error("active function wrong");

    // Free code follows software level
    property p_free_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_FREE && !power_on_load) |=>
            (digital_output_zero == $past(sw_level[0]));
    endproperty
    a_free_fn: assert property (p_free_fn)
        else $error("free output not following software level");

    // Selected error follows any class 1-4 error
    property p_err_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_SEL_ERROR && !power_on_load) |=>
            (digital_output_zero == |$past(status.err_class_1_4));
    endproperty
    a_err_fn: assert property (p_err_fn)
        else $error("selected error output wrong");

    // Position register channel 4 on code 21
    property p_preg_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[1] == `FN_PREG_4 && !power_on_load) |=>
            (digital_output_one == $past(status.preg_channel[3]));
    endproperty
    a_preg_fn: assert property (p_preg_fn)
        else $error("position register channel output wrong");

    // Negative direction on code 23
    property p_neg_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_MOVE_NEG && !power_on_load) |=>
            (digital_output_zero == $past(status.move_neg));
    endproperty
    a_neg_fn: assert property (p_neg_fn)
        else $error("negative direction output wrong");

    // No-fault code high in switched on state
    property p_no_fault_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_NO_FAULT &&
         status.op_state == `ST_SWITCHED_ON) |=> digital_output_zero;
    endproperty
    a_no_fault_fn: assert property (p_no_fault_fn)
        else $error("no-fault output low in switched on state");

    // Relative move after capture drives output high
    property p_rel_move_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_REL_MOVE && status.rel_move_capture) |=>
            digital_output_zero;
    endproperty
    a_rel_move_fn: assert property (p_rel_move_fn)
        else $error("relative move output low");

    // Position deviation window drives output high
    property p_pos_win_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_POS_WIN && status.pos_in_window) |=>
            digital_output_zero;
    endproperty
    a_pos_win_fn: assert property (p_pos_win_fn)
        else $error("position window output low");

    // Current below threshold drives output high
    property p_cur_low_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_CUR_LOW && status.cur_below_thr) |=>
            digital_output_zero;
    endproperty
    a_cur_low_fn: assert property (p_cur_low_fn)
        else $error("current threshold output low");

    // Halt acknowledge drives output high
    property p_halt_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_HALT_ACK && status.halt_ack) |=>
            digital_output_zero;
    endproperty
    a_halt_fn: assert property (p_halt_fn)
        else $error("halt acknowledge output low");

    // Sequence start acknowledge drives output high
    property p_start_ack_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_SEQ_START_ACK && status.seq_start_ack) |=>
            digital_output_zero;
    endproperty
    a_start_ack_fn: assert property (p_start_ack_fn)
        else $error("start acknowledge output low");

    // Standstill drives output high
    property p_standstill_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_STANDSTILL && status.standstill) |=>
            digital_output_zero;
    endproperty
    a_standstill_fn: assert property (p_standstill_fn)
        else $error("standstill output low");

    // Valid reference drives output high
    property p_ref_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_REF_OK && status.ref_valid) |=>
            digital_output_zero;
    endproperty
    a_ref_fn: assert property (p_ref_fn)
        else $error("reference valid output low");

    // Class zero warning drives output high
    property p_warn_fn;
        @(posedge clk) disable iff (rst)
        (active_sel[0] == `FN_SEL_WARNING && status.err_class_0) |=>
            digital_output_zero;
    endproperty
    a_warn_fn: assert property (p_warn_fn)
        else $error("selected warning output low");

    // Power-on strobe copies both stored selectors into the mapping
    sequence s_power_on;
        power_on_load;
    endsequence
    sequence s_copied;
        (active_sel[0] == $past(stored_sel[0])) &&
        (active_sel[1] == $past(stored_sel[1]));
    endsequence
    property p_load_copies;
        @(posedge clk) disable iff (rst)
        s_power_on |=> s_copied;
    endproperty
    a_load_copies: assert property (p_load_copies)
        else $error("power-on load did not copy selectors");

    // Write to output one selector leaves output zero selector alone
    property p_independent;
        @(posedge clk) disable iff (rst)
        (req.wr_en && hit[1]) |=> $stable(stored_sel[0]);
    endproperty
    a_independent: assert property (p_independent)
        else $error("output one write disturbed output zero selector");

endmodule

// [bench/output_load_model.sv]
// External equipment that samples the two digital output lines
`timescale 1ns/1ps

module output_load_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Output lines from the drive
    input  wire logic line0,
    input  wire logic line1,
    // Levels seen by the equipment
    output logic      seen0_ff,
    output logic      seen1_ff
);
    // Receiver flops, one cycle behind the lines
    always_ff @(posedge clk) begin
        if (rst) begin
            seen0_ff <= 1'b0;
            seen1_ff <= 1'b0;
        end else begin
            seen0_ff <= line0;
            seen1_ff <= line1;
        end
    end
endmodule

// [bench/tb_signal_output_function_select.sv]
// Self-checking bench for the output function mapper
`timescale 1ns/1ps
`include "output_function_map.svh"

module tb_signal_output_function_select;
    import output_function_pkg::*;
    typedef struct packed {
        logic [15:0]   code;
        drive_status_t st;
        logic [1:0]    sw;
        logic          exp0;
    } row_t;
    logic          clk, rst, power_on_load, power_stage_enabled;
    reg_req_t      req;
    logic [1:0]    sw_level;
    drive_status_t status, s;
    logic [15:0]   rdata_ff;
    wr_result_t    wr_result_ff;
    logic          out0, out1, seen0, seen1;
    int            fail_count, n_tests;
    row_t          rows[$];
    int codes[21] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 13, 14, 15, 16,
                      17, 18, 19, 20, 21, 22, 23};
    int bad[4] = '{0, 10, 12, 24};

    signal_output_function_select u_signal_output_function_select (
        .clk(clk), .rst(rst), .power_on_load(power_on_load),
        .power_stage_enabled(power_stage_enabled), .req(req),
        .rdata_ff(rdata_ff), .wr_result_ff(wr_result_ff),
        .sw_level(sw_level), .status(status),
        .digital_output_zero(out0), .digital_output_one(out1));
    output_load_model u_output_load_model (
        .clk(clk), .rst(rst), .line0(out0), .line1(out1),
        .seen0_ff(seen0), .seen1_ff(seen1));

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Status with only the condition of one code set
    function automatic drive_status_t on_st(input int c);
        drive_status_t t;
        t = '0;
        case (c)
            2, 3: t.op_state = `ST_OP_ENABLED;
            4: t.rel_move_capture = 1'b1;
            5: t.pos_in_window = 1'b1;
            6: t.vel_in_window = 1'b1;
            7: t.vel_below_thr = 1'b1;
            8: t.cur_below_thr = 1'b1;
            9: t.halt_ack = 1'b1;
            11: t.seq_start_ack = 1'b1;
            13: t.standstill = 1'b1;
            14: t.err_class_1_4 = 4'h8;
            15: t.ref_valid = 1'b1;
            16: t.err_class_0 = 1'b1;
            17: t.seq_done = 1'b1;
            18, 19, 20, 21: t.preg_channel[c-18] = 1'b1;
            22: t.move_pos = 1'b1;
            23: t.move_neg = 1'b1;
            default: ;
        endcase
        return t;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input wr_result_t r);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
        #1 chk({14'h0000, wr_result_ff}, {14'h0000, r});
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '0;
        #1 chk(rdata_ff, exp);
    endtask

    task automatic pon();
        @(posedge clk);
        power_on_load <= 1'b1;
        @(posedge clk);
        power_on_load <= 1'b0;
    endtask

    task automatic apply(input drive_status_t t, input logic [1:0] w);
        @(posedge clk);
        status <= t;
        sw_level <= w;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        #(3000 * 40);
        fail_count++;
        summarize();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        power_on_load = 1'b0;
        power_stage_enabled = 1'b0;
        req = '0;
        sw_level = 2'b00;
        status = '0;
        fail_count = 0;
        n_tests = 0;
        foreach (codes[i]) begin
            rows.push_back('{16'(codes[i]), on_st(codes[i]),
                             (codes[i] == 1) ? 2'b01 : 2'b00, 1'b1});
            rows.push_back('{16'(codes[i]), '0,
                             (codes[i] == 1) ? 2'b10 : 2'b00, 1'b0});
        end
        s = '0;
        s.op_state = `ST_READY_TO_SWITCH;
        rows.push_back('{16'h0002, s, 2'b00, 1'b1});
        rows.push_back('{16'h0003, s, 2'b00, 1'b0});
        s.op_state = `ST_SWITCHED_ON;
        rows.push_back('{16'h0002, s, 2'b00, 1'b1});
        s.op_state = 3'h4;
        rows.push_back('{16'h0002, s, 2'b00, 1'b0});
        s.op_state = `ST_OP_ENABLED;
        s.err_class_1_4 = 4'h1;
        rows.push_back('{16'h000e, s, 2'b00, 1'b1});
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Row table: selector zero walks all codes, one stays active
        foreach (rows[i]) begin
            if (i == 0 || rows[i].code != rows[i-1].code) begin
                wr(`OFS_SEL0, rows[i].code, WR_ACCEPTED);
                pon();
            end
            apply(rows[i].st, rows[i].sw);
            chk({15'h0000, seen0},
                {15'h0000, rows[i].exp0});
            chk({15'h0000, seen1},
                {15'h0000, rows[i].st.op_state == 3'h3});
        end
        $display("test row table done");
        // Refused writes keep the old value
        @(posedge clk);
        power_stage_enabled <= 1'b1;
        wr(`OFS_SEL1, 16'h0005, WR_REJECTED);
        @(posedge clk);
        power_stage_enabled <= 1'b0;
        foreach (bad[i]) begin
            wr(`OFS_SEL0, bad[i][15:0], WR_REJECTED);
            wr(`OFS_SEL1, bad[i][15:0], WR_REJECTED);
        end
        rd(`OFS_SEL0, `FN_SEL_ERROR);
        rd(`OFS_SEL1, `FN_ACTIVE);
        $display("test refused writes done");
        // New value stored but mapping waits for power-on
        s = '0;
        s.op_state = `ST_OP_ENABLED;
        wr(`OFS_SEL1, `FN_VEL_LOW, WR_ACCEPTED);
        rd(`OFS_SEL1, `FN_VEL_LOW);
        apply(s, 2'b00);
        chk({15'h0000, seen1}, 16'h0001);
        pon();
        apply(s, 2'b00);
        chk({15'h0000, seen1}, 16'h0000);
        $display("test deferred mapping done");
        // Output one on position register channel four
        wr(`OFS_SEL1, `FN_PREG_4, WR_ACCEPTED);
        pon();
        apply(on_st(21), 2'b00);
        chk({15'h0000, seen1}, 16'h0001);
        apply(on_st(20), 2'b00);
        chk({15'h0000, seen1}, 16'h0000);
        $display("test position register output done");
        // Unmapped address
        wr(16'h0716, 16'h0001, WR_IDLE);
        rd(16'h0716, 16'h0000);
        $display("test unmapped address done");
        // Second reset restores defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_SEL0, `SEL0_DEFAULT);
        rd(`OFS_SEL1, `SEL1_DEFAULT);
        apply(s, 2'b00);
        chk({14'h0000, seen1, seen0}, 16'h0003);
        $display("test reset defaults done");
        summarize();
    end
endmodule
